// File: logic/smer_monitor_top.v
`timescale 1ns/10ps
`include "smer_consts.vh"

// ----------------------------------------------------------------------
// Error-rate self monitor: attributes, schedule, off-line run, report.
// ----------------------------------------------------------------------
module smer_monitor_top
#(
   parameter        NUM_ATTR      = 4,
   parameter [27:0] TICKS_PER_SEC = `SMER_TICKS_PER_SEC,
   parameter [15:0] PERIOD_SEC    = `SMER_PERIOD_SEC,
   parameter [31:0] ONLINE_CYC    = `SMER_ONLINE_MS * `SMER_MS_CYCLES,
   parameter [31:0] FULL_CYC      = `SMER_FULL_MS * `SMER_MS_CYCLES
)
(
   // Clock and reset.
   input  wire                clk,
   input  wire                sys_rst,
   // Mode page control bits.
   input  wire                exception_disable,
   input  wire                online_only_select,
   input  wire                reportEnable,
   // Host commands.
   input  wire                rezeroReq,
   input  wire                logSenseReq,
   input  wire [7:0]          logSensePage,
   input  wire                busIdle,
   // Drive operations, one bit per attribute.
   input  wire [NUM_ATTR-1:0] opDone,
   input  wire [NUM_ATTR-1:0] opError,
   // Nonvolatile store of the reported code.
   input  wire                nvFailStored,
   output reg                 nvFailWrite,
   // Off-line measurement handshake to the drive firmware side.
   output reg                 measureBusy,
   output reg                 measureSave,
   // Log sense answer.
   output reg                 logValid,
   output reg  [15:0]         logSecondsLeft,
   // Exception report.
   output reg                 senseValid,
   output reg  [7:0]          senseKey,
   output reg  [7:0]          senseAsc,
   output reg  [7:0]          senseAscq
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_RUN  = 2'h1;
   localparam [1:0] ST_SAVE = 2'h2;

   reg  [1:0]          state;
   reg  [1:0]          next_state;
   reg  [31:0]         runCount;
   reg  [31:0]         runLimit;
   reg                 restartTimer;
   reg                 failLatched;
   wire                enable;
   wire [NUM_ATTR-1:0] attrFail;
   wire [15:0]         secondsLeft;
   wire                due;
   wire                startRun;

   assign enable = !exception_disable;

   // -------------------------------------------------------------------
   // Attribute monitors
   // -------------------------------------------------------------------
   // Each attribute collects on-line data from normal operations.
   genvar g;
   generate
      for (g = 0; g < NUM_ATTR; g = g + 1)
      begin : gAttr
         smer_attr_monitor
         #(
            .INTERVAL_LEN (`SMER_INTERVAL_LEN),
            .ERR_THRESH   (`SMER_ERR_THRESH),
            .HIST_THRESH  (`SMER_HIST_THRESH)
         )
         uAttr
         (
            .clk         (clk),
            .sys_rst     (sys_rst),
            .enable      (enable),
            .opDone      (opDone[g]),
            .opError     (opError[g]),
            .predictFail (attrFail[g])
         );
      end
   endgenerate

   // -------------------------------------------------------------------
   // Schedule timer
   // -------------------------------------------------------------------
   smer_scheduler
   #(
      .TICKS_PER_SEC (TICKS_PER_SEC),
      .PERIOD_SEC    (PERIOD_SEC)
   )
   uSched
   (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .enable      (enable),
      .restart     (restartTimer),
      .secondsLeft (secondsLeft),
      .due         (due)
   );

   // -------------------------------------------------------------------
   // Off-line measurement sequencer
   // -------------------------------------------------------------------
   // A run starts on rezero, or when due and the bus is idle; never in
   // online-only mode or when disabled.
   assign startRun = enable && !online_only_select &&
                     (rezeroReq || (due && busIdle));

   // Next state; once running, host activity cannot stop the run.
   always @*
   begin
      next_state = state;
      case (state)
         ST_IDLE:
            if (startRun)
               next_state = ST_RUN;
         ST_RUN:
            if (runCount + 32'h00000001 >= runLimit)
               next_state = ST_SAVE;
         ST_SAVE:
            next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
   end

   // Sequencer registers; the stall is bounded by the mode's limit.
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state        <= ST_IDLE;
         runCount     <= 32'h00000000;
         runLimit     <= 32'h00000001;
         restartTimer <= 1'b0;
         measureBusy  <= 1'b0;
         measureSave  <= 1'b0;
      end
      else
      begin
         state        <= next_state;
         restartTimer <= (state == ST_IDLE) && startRun;
         measureSave  <= (state == ST_RUN) && (next_state == ST_SAVE);
         measureBusy  <= (next_state == ST_RUN);
         if (state == ST_IDLE)
         begin
            runCount <= 32'h00000000;
            runLimit <= online_only_select ? ONLINE_CYC : FULL_CYC;
         end
         else if (state == ST_RUN)
            runCount <= runCount + 32'h00000001;
      end
   end

   // -------------------------------------------------------------------
   // Log sense answer
   // -------------------------------------------------------------------
   // Page 0x3e returns seconds until the next scheduled measurement.
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         logValid       <= 1'b0;
         logSecondsLeft <= 16'h0000;
      end
      else
      begin
         logValid <= logSenseReq && (logSensePage == `SMER_LOG_PAGE);
         if (logSenseReq && (logSensePage == `SMER_LOG_PAGE))
            logSecondsLeft <= secondsLeft;
      end
   end

   // -------------------------------------------------------------------
   // Predictive failure report
   // -------------------------------------------------------------------
   // The failure is latched from any attribute or from the stored copy,
   // so it returns after a reset; a new failure is written to the store.
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         failLatched <= 1'b0;
         nvFailWrite <= 1'b0;
         senseValid  <= 1'b0;
         senseKey    <= 8'h00;
         senseAsc    <= 8'h00;
         senseAscq   <= 8'h00;
      end
      else
      begin
         failLatched <= failLatched || nvFailStored || (|attrFail);
         nvFailWrite <= (|attrFail) && !failLatched && !nvFailStored;
         senseValid  <= enable && reportEnable && failLatched;
         if (enable && reportEnable && failLatched)
         begin
            senseKey  <= `SMER_SENSE_KEY;
            senseAsc  <= `SMER_SENSE_ASC;
            senseAscq <= `SMER_SENSE_ASCQ;
         end
         else
         begin
            senseKey  <= 8'h00;
            senseAsc  <= 8'h00;
            senseAscq <= 8'h00;
         end
      end
   end

endmodule // smer_monitor_top

// File: inc/smer_consts.vh
// How it works
// - Exception disable turns off collection, scheduling and reporting entirely.
// - While enabled, attribute data is gathered alongside normal operations.
// - Online-only select skips all off-line measurement and data saving.
// - A rezero request forces an off-line measurement immediately.
// - A forced measurement restarts the two-hour schedule timer.
// - Log page 0x3e request returns time left until next measurement.
// - Scheduled measurement runs once per two hours, only with idle bus.
// - A started measurement runs to completion, ignoring host activity.
// - Stall is at most 42 ms online-only and 163 ms fully enabled.
// - Predictive failure reports sense code 01-5d00 via selected method.
// - The reported failure code survives bus resets and power cycles.
// - Each attribute has an interval counter of completed operations.
// - Each attribute has a failure counter of errors within the interval.
// - Failures exceeding threshold before interval end mean unacceptable rate.
// - Interval end without exceeding threshold means acceptable rate.
// - After either verdict both counters clear and a new interval starts.
// - History counter rises on bad, falls on good; threshold flags failure.
`ifndef SMER_CONSTS_VH
`define SMER_CONSTS_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SMER_CLK_MHZ        200
`define SMER_TICKS_PER_SEC  28'd200000000
`define SMER_PERIOD_SEC     7200
`define SMER_ONLINE_MS      42
`define SMER_FULL_MS        163
`define SMER_MS_CYCLES      (`SMER_CLK_MHZ * 1000)

// ----------------------------------------------------------------------
// Host-side codes
// ----------------------------------------------------------------------
`define SMER_LOG_PAGE       8'h3e
`define SMER_SENSE_KEY      8'h01
`define SMER_SENSE_ASC      8'h5d
`define SMER_SENSE_ASCQ     8'h00

// ----------------------------------------------------------------------
// Per-attribute limits
// ----------------------------------------------------------------------
`define SMER_INTERVAL_LEN   16'h0400
`define SMER_ERR_THRESH     16'h0010
`define SMER_HIST_THRESH    8'h08

`endif

// File: logic/smer_attr_monitor.v
`timescale 1ns/10ps
`include "smer_consts.vh"

// ----------------------------------------------------------------------
// One attribute: interval, failure and history counters.
// ----------------------------------------------------------------------
module smer_attr_monitor
#(
   parameter [15:0] INTERVAL_LEN = `SMER_INTERVAL_LEN,
   parameter [15:0] ERR_THRESH   = `SMER_ERR_THRESH,
   parameter [7:0]  HIST_THRESH  = `SMER_HIST_THRESH
)
(
   // Clock and reset.
   input  wire clk,
   input  wire sys_rst,
   // Events.
   input  wire enable,
   input  wire opDone,
   input  wire opError,
   // Verdict.
   output reg  predictFail
);

   reg [15:0] intervalCount;
   reg [15:0] failCount;
   reg [7:0]  history;
   wire [15:0] next_fail;
   wire        badRate;
   wire        goodRate;

   assign next_fail = failCount + {15'h0000, opError};
   // Errors over threshold end the interval early as unacceptable.
   assign badRate  = enable && (next_fail > ERR_THRESH);
   assign goodRate = enable && !badRate && opDone &&
                     (intervalCount + 16'h0001 >= INTERVAL_LEN);

   // Counters; interval and failure counts clear after any verdict or when disabled.
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         intervalCount <= 16'h0000;
         failCount     <= 16'h0000;
         history       <= 8'h00;
         predictFail   <= 1'b0;
      end
      else if (!enable)
      begin
         intervalCount <= 16'h0000;
         failCount     <= 16'h0000;
      end
      else
      begin
         if (badRate || goodRate)
         begin
            intervalCount <= 16'h0000;
            failCount     <= 16'h0000;
         end
         else
         begin
            if (opDone)
               intervalCount <= intervalCount + 16'h0001;
            failCount <= next_fail;
         end
         if (badRate && history != 8'hff)
            history <= history + 8'h01;
         else if (goodRate && history != 8'h00)
            history <= history - 8'h01;
         if (badRate && history + 8'h01 >= HIST_THRESH)
            predictFail <= 1'b1;
      end
   end

endmodule // smer_attr_monitor

// File: logic/smer_scheduler.v
`timescale 1ns/10ps
`include "smer_consts.vh"

// ----------------------------------------------------------------------
// Two-hour schedule timer: seconds remaining until next measurement.
// ----------------------------------------------------------------------
module smer_scheduler
#(
   parameter [27:0] TICKS_PER_SEC = `SMER_TICKS_PER_SEC,
   parameter [15:0] PERIOD_SEC    = `SMER_PERIOD_SEC
)
(
   // Clock and reset.
   input  wire        clk,
   input  wire        sys_rst,
   // Control.
   input  wire        enable,
   input  wire        restart,
   // Status.
   output reg  [15:0] secondsLeft,
   output reg         due
);

   reg [27:0] tick;

   // Count down once per second; a restart reloads the full period.
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tick        <= 28'h0000000;
         secondsLeft <= PERIOD_SEC;              // No run falls due at once.
         due         <= 1'b0;
      end
      else if (!enable || restart)
      begin
         tick        <= 28'h0000000;
         secondsLeft <= PERIOD_SEC;
         due         <= 1'b0;
      end
      else if (secondsLeft == 16'h0000)
         due <= 1'b1;
      else if (tick + 28'h0000001 >= TICKS_PER_SEC)
      begin
         tick        <= 28'h0000000;
         secondsLeft <= secondsLeft - 16'h0001;
      end
      else
         tick <= tick + 28'h0000001;
   end

endmodule // smer_scheduler

// File: verif/smer_port_monitor.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Port checker for the error-rate self monitor.
// ----------------------------------------------------------------------
module smer_port_monitor
#(
   parameter [15:0] PERIOD_SEC = 16'h0005,
   parameter [31:0] FULL_CYC   = 32'h00000014
)
(
   // Clock and reset.
   input wire        clk,
   input wire        sys_rst,
   // Control and host requests.
   input wire        exception_disable,
   input wire        online_only_select,
   input wire        reportEnable,
   input wire        rezeroReq,
   input wire        logSenseReq,
   input wire [7:0]  logSensePage,
   input wire        nvFailStored,
   // Outputs of the block.
   input wire        measureBusy,
   input wire        measureSave,
   input wire        logValid,
   input wire [15:0] logSecondsLeft,
   input wire        senseValid,
   input wire [7:0]  senseKey,
   input wire [7:0]  senseAsc,
   input wire [7:0]  senseAscq
);
   reg [31:0] busyCnt;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Counts the cycles of the current off-line run.
   always @(posedge clk or posedge sys_rst)
      if (sys_rst)
         busyCnt <= 32'h0;
      else if (measureBusy)
         busyCnt <= busyCnt + 32'h1;
      else
         busyCnt <= 32'h0;

   property p_log_ans;
      logSenseReq && logSensePage == 8'h3e && !exception_disable |=> logValid;
   endproperty
   a_log_ans: assert property (p_log_ans)
      else $error("log answer missing");
   property p_log_ref;
      !(logSenseReq && logSensePage == 8'h3e) |=> !logValid;
   endproperty
   a_log_ref: assert property (p_log_ref)
      else $error("log answer without valid request");
   property p_log_val;
      logValid |-> logSecondsLeft <= PERIOD_SEC;
   endproperty
   a_log_val: assert property (p_log_val)
      else $error("seconds left above period");
   property p_rezero;
      rezeroReq && !measureBusy && !measureSave && !exception_disable
         && !online_only_select |=> measureBusy;
   endproperty
   a_rezero: assert property (p_rezero)
      else $error("forced run did not start");
   property p_no_run;
      $rose(measureBusy) |-> !$past(online_only_select)
         && !$past(exception_disable);
   endproperty
   a_no_run: assert property (p_no_run)
      else $error("run started while barred");
   property p_hold;
      measureBusy && busyCnt < FULL_CYC - 32'h1 |=> measureBusy;
   endproperty
   a_hold: assert property (p_hold)
      else $error("run cut short");
   property p_stall;
      busyCnt <= FULL_CYC;
   endproperty
   a_stall: assert property (p_stall)
      else $error("run too long");
   property p_save;
      $fell(measureBusy) |-> ##[0:1] measureSave;
   endproperty
   a_save: assert property (p_save)
      else $error("no save at end of run");
   property p_code;
      senseValid |-> {senseKey, senseAsc, senseAscq} == 24'h015d00;
   endproperty
   a_code: assert property (p_code)
      else $error("wrong sense code");
   property p_quiet;
      exception_disable [*3] |-> !senseValid;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("report while disabled");
   property p_nv;
      (nvFailStored && reportEnable && !exception_disable) [*4] |-> senseValid;
   endproperty
   a_nv: assert property (p_nv)
      else $error("stored failure not reported");

   // Main scenarios seen.
   c_log: cover property (logValid);
   c_run: cover property ($fell(measureBusy));
   c_fail: cover property (senseValid);
endmodule // smer_port_monitor

bind smer_monitor_top smer_port_monitor #(.PERIOD_SEC(PERIOD_SEC),
   .FULL_CYC(FULL_CYC)) smer_port_monitor_inst (.clk(clk),
   .sys_rst(sys_rst), .exception_disable(exception_disable),
   .online_only_select(online_only_select), .reportEnable(reportEnable),
   .rezeroReq(rezeroReq), .logSenseReq(logSenseReq),
   .logSensePage(logSensePage), .nvFailStored(nvFailStored),
   .measureBusy(measureBusy), .measureSave(measureSave),
   .logValid(logValid), .logSecondsLeft(logSecondsLeft),
   .senseValid(senseValid), .senseKey(senseKey), .senseAsc(senseAsc),
   .senseAscq(senseAscq));

// File: verif/smer_nv_store.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Nonvolatile failure flag kept outside the monitor.
// ----------------------------------------------------------------------
module smer_nv_store
(
   // Clock.
   input  wire clk,
   // Store port.
   input  wire nvFailWrite,
   output reg  nvFailStored
);
   // No reset: the flag must outlive bus resets and power cycles.
   initial nvFailStored = 1'b0;

   // A write pulse sets the flag for good.
   always @(posedge clk)
      if (nvFailWrite)
         nvFailStored <= 1'b1;
endmodule // smer_nv_store

// File: verif/smer_monitor_top_tb_top.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Self-checking bench of the error-rate self monitor.
// ----------------------------------------------------------------------
module smer_monitor_top_tb_top;
   localparam [15:0] PSEC = 16'h0005;
   localparam [31:0] FULL = 32'h00000014;
   reg         clk, sys_rst, exception_disable, online_only_select;
   reg         reportEnable, rezeroReq, logSenseReq, busIdle, bad, saw;
   reg  [7:0]  logSensePage, h;
   reg  [3:0]  opDone, opError;
   reg  [31:0] seed;
   wire        nvFailStored, nvFailWrite, measureBusy, measureSave;
   wire        logValid, senseValid;
   wire [15:0] logSecondsLeft;
   wire [7:0]  senseKey, senseAsc, senseAscq;
   integer     num_errors, checks_done, cyc, i, j, k, n;

   smer_monitor_top #(.TICKS_PER_SEC(28'h000000a), .PERIOD_SEC(PSEC),
      .ONLINE_CYC(32'h8), .FULL_CYC(FULL)) smer_monitor_top_inst (
      .clk(clk), .sys_rst(sys_rst), .exception_disable(exception_disable),
      .online_only_select(online_only_select), .reportEnable(reportEnable),
      .rezeroReq(rezeroReq), .logSenseReq(logSenseReq),
      .logSensePage(logSensePage), .busIdle(busIdle), .opDone(opDone),
      .opError(opError), .nvFailStored(nvFailStored),
      .nvFailWrite(nvFailWrite), .measureBusy(measureBusy),
      .measureSave(measureSave), .logValid(logValid),
      .logSecondsLeft(logSecondsLeft), .senseValid(senseValid),
      .senseKey(senseKey), .senseAsc(senseAsc), .senseAscq(senseAscq));
   smer_nv_store smer_nv_store_inst (.clk(clk), .nvFailWrite(nvFailWrite),
      .nvFailStored(nvFailStored));

   // Xorshift source of the random stimulus.
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction

   // Expected failure history after one judged interval.
   function [7:0] hnext(input [7:0] hv, input badv);
      hnext = badv ? hv + 8'h1 : (hv == 8'h0 ? 8'h0 : hv - 8'h1);
   endfunction

   task chk1(input got, input exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp)
         begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t flag %b want %b", $time, got, exp);
         end
      end
   endtask

   task chkv(input [23:0] got, input [23:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp)
         begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t value %h want %h", $time, got, exp);
         end
      end
   endtask

   // One log request; the answer is due one cycle after it is taken.
   task logq(input [7:0] pg, input ok);
      begin
         @(posedge clk);
         logSenseReq <= 1'b1;
         logSensePage <= pg;
         @(posedge clk);
         logSenseReq <= 1'b0;
         #1;
         chk1(logValid, ok);
         if (ok)
            chkv({8'h0, logSecondsLeft}, {8'h0, PSEC});
      end
   endtask

   // Forced run with host traffic during it; counts the busy cycles.
   task rz(input run);
      begin
         @(posedge clk);
         rezeroReq <= 1'b1;
         n = 0;
         saw = 1'b0;
         for (k = 0; k < 40; k = k + 1)
         begin
            @(posedge clk);
            rezeroReq <= (k > 2 && k < 9) ? seed[0] : 1'b0;
            logSenseReq <= (k == 1);
            logSensePage <= 8'h3e;
            seed = xs(seed);
            #1;
            if (measureBusy)
               n = n + 1;
            if (measureSave)
               saw = 1'b1;
            if (k == 2 && run)
               chkv({8'h0, logSecondsLeft}, {8'h0, PSEC});
         end
         chkv(n[23:0], run ? FULL[23:0] : 24'h0);
         chk1(saw, run);
      end
   endtask

   task conclude;
      begin
         $display("checks %0d errors %0d", checks_done, num_errors);
         if (num_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask

   // Free-running 200 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Cuts a hung run short.
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         num_errors = num_errors + 1;
         conclude;
      end
   end

   // Main sequence.
   initial
   begin
      {exception_disable, online_only_select, rezeroReq, logSenseReq} = 0;
      {busIdle, opDone, opError, logSensePage, reportEnable} = 0;
      sys_rst = 1'b1;
      seed = 32'hb822;
      {num_errors, checks_done, cyc} = 0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      chk1(measureBusy | logValid | senseValid | measureSave, 1'b0);
      logq(8'h3e, 1'b1);
      for (j = 0; j < 6; j = j + 1)
      begin
         seed = xs(seed);
         logq(seed[7:0] == 8'h3e ? 8'h3f : seed[7:0], 1'b0);
      end
      repeat (10) @(posedge clk);
      rz(1'b1);
      online_only_select <= 1'b1;
      rz(1'b0);
      online_only_select <= 1'b0;
      exception_disable <= 1'b1;
      rz(1'b0);
      exception_disable <= 1'b0;
      saw = 1'b0;
      for (j = 0; j < 120; j = j + 1)
      begin
         @(posedge clk);
         #1;
         saw = saw | measureBusy;
      end
      chk1(saw, 1'b0);
      busIdle <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk1(measureBusy, 1'b1);
      repeat (30) @(posedge clk);
      busIdle <= 1'b0;
      reportEnable <= 1'b1;
      seed = xs(seed);
      i = seed[1:0];
      h = 8'h0;
      for (j = 0; j < 11; j = j + 1)
      begin
         bad = (j != 0 && j != 8);
         for (k = 0; k < (bad ? 17 : 1024); k = k + 1)
         begin
            @(posedge clk);
            seed = xs(seed);
            opDone <= (seed[3:0] & ~(4'h1 << i)) | (4'h1 << i);
            opError <= bad ? (4'h1 << i) : 4'h0;
         end
         @(posedge clk);
         {opDone, opError} <= 8'h0;
         repeat (5) @(posedge clk);
         #1;
         h = hnext(h, bad);
         chk1(senseValid, h >= 8'h08);
      end
      chkv({senseKey, senseAsc, senseAscq}, 24'h015d00);
      chk1(nvFailStored, 1'b1);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      chk1(senseValid, 1'b1);
      reportEnable <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk1(senseValid, 1'b0);
      reportEnable <= 1'b1;
      exception_disable <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk1(senseValid, 1'b0);
      conclude;
   end
endmodule // smer_monitor_top_tb_top
